/* File: design/addr_gen_pkg.sv */
/*
 * Shared constants, types and decode helpers for the data memory
 * operand address generator.
 * Assumes a 12-bit linear data space with the pointer SFR block
 * placed just below the top of memory.
 */
package addr_gen_pkg;

    localparam int ADDR_W = 12;
    localparam int DATA_W = 8;
    localparam int PAIR_COUNT = 3;

    // pointer SFR block: pair n occupies base - 8*n down to base - 8*n - 6
    localparam logic [11:0] PAIR0_BASE = 12'hfef;
    localparam logic [11:0] PAIR_STRIDE = 12'h008;
    localparam logic [11:0] INDIRECT_ONE_ADDR = 12'hfe7;

    // slot = distance below the pair's base address
    localparam logic [2:0] SLOT_PLAIN = 3'h0;
    localparam logic [2:0] SLOT_POST_INCREMENT_OPERAND = 3'h1;
    localparam logic [2:0] SLOT_POST_DECREMENT_OPERAND = 3'h2;
    localparam logic [2:0] SLOT_PRE_INCREMENT_OPERAND = 3'h3;
    localparam logic [2:0] SLOT_OFFSET_BY_WORKING_OPERAND = 3'h4;
    localparam logic [2:0] SLOT_HIGH = 3'h5;
    localparam logic [2:0] SLOT_LOW = 3'h6;

    localparam logic [11:0] PTR_RESET = 12'h000;
    localparam logic [11:0] PTR_STEP = 12'h001;
    localparam logic [3:0] HIGH_UNUSED_FILL = 4'h0;
    localparam logic [7:0] RD_NULL = 8'h00;

    localparam logic [7:0] ACCESS_SPLIT = 8'h60;
    localparam logic [7:0] LITERAL_OFFSET_MAX = 8'h5f;
    localparam logic [3:0] FORCED_BANK = 4'hf;
    localparam logic [3:0] LOW_BANK = 4'h0;

    typedef enum logic [4:0] {
        PTR_HOLD = 5'b00001,
        PTR_INC = 5'b00010,
        PTR_DEC = 5'b00100,
        PTR_WR_LO = 5'b01000,
        PTR_WR_HI = 5'b10000
    } ptr_op_t;

    typedef enum logic [1:0] {
        ST_IDLE = 2'b01,
        ST_ACCESS = 2'b10
    } state_t;

    typedef struct packed {
        logic hit;
        logic [1:0] pair;
        logic [2:0] slot;
    } sfr_class_t;

    function automatic sfr_class_t classify(input logic [11:0] addr);
        sfr_class_t c;
        logic [11:0] diff;
        c = '0;
        diff = '0;
        for (int n = 0; n < PAIR_COUNT; n++)
        begin
            diff = 12'(PAIR0_BASE - 12'(n * PAIR_STRIDE) - addr);
            if (diff <= 12'(SLOT_LOW))
            begin
                c.hit = 1'b1;
                c.pair = 2'(n);
                c.slot = diff[2:0];
            end
        end
        return c;
    endfunction

    function automatic logic is_virtual(input logic [2:0] slot);
        return slot <= SLOT_OFFSET_BY_WORKING_OPERAND;
    endfunction

endpackage

/* File: design/pointer_pair.sv */
/*
 * One 12-bit pointer pair with byte writes and whole-pair step.
 * Assumes the caller issues at most one operation per clock.
 */
`timescale 1ns/1ps
`default_nettype none
module pointer_pair (
    input wire logic clk,
    input wire logic srst,
    input wire addr_gen_pkg::ptr_op_t op,
    input wire logic [7:0] wdata,
    output logic [11:0] ptr
);
    import addr_gen_pkg::*;

    typedef struct packed {
        logic [11:0] ptr;
    } pair_state_t;

    pair_state_t st_r;
    pair_state_t st_nxt;

    always_comb
    begin
        st_nxt = st_r;
        unique case (op)
            PTR_HOLD:
            begin
                st_nxt.ptr = st_r.ptr;
            end
            // full 12-bit step, low byte carries into high, wraps at the ends
            PTR_INC:
            begin
                st_nxt.ptr = 12'(st_r.ptr + PTR_STEP);
            end
            PTR_DEC:
            begin
                st_nxt.ptr = 12'(st_r.ptr - PTR_STEP);
            end
            PTR_WR_LO:
            begin
                st_nxt.ptr = {st_r.ptr[11:8], wdata};
            end
            // only the low nibble of the high byte is kept
            PTR_WR_HI:
            begin
                st_nxt.ptr = {wdata[3:0], st_r.ptr[7:0]};
            end
            default:
            begin
                st_nxt.ptr = st_r.ptr;
            end
        endcase
    end

    always_ff @(posedge clk)
    begin
        if (srst)
            st_r <= '{ptr: PTR_RESET};
        else
            st_r <= st_nxt;
    end

    assign ptr = st_r.ptr;

endmodule
`default_nettype wire

/* File: design/operand_address_former.sv */
/*
 * Forms the direct operand address from the access bit, file address,
 * bank select and the extended literal offset mode.
 * Purely combinational; inputs are held by the caller for the request cycle.
 */
`timescale 1ns/1ps
`default_nettype none
module operand_address_former (
    input wire logic access_bit,
    input wire logic [7:0] file_addr,
    input wire logic [3:0] bank_select_register,
    input wire logic extended_instruction_config_bit,
    input wire logic [11:0] pair_two_ptr,
    output logic [11:0] direct_addr
);
    import addr_gen_pkg::*;

    always_comb
    begin
        if (access_bit)
            direct_addr = {bank_select_register, file_addr};
        else if (extended_instruction_config_bit && file_addr <= LITERAL_OFFSET_MAX)
            direct_addr = 12'(pair_two_ptr + {4'h0, file_addr});
        else if (file_addr >= ACCESS_SPLIT)
            direct_addr = {FORCED_BANK, file_addr};
        else
            direct_addr = {LOW_BANK, file_addr};
    end

endmodule
`default_nettype wire

/* File: design/data_memory_address_generator.sv */
/*
 * Operand address generator: direct, banked, literal-offset and
 * pointer-indirect access to the 12-bit data space, including the
 * three pointer pairs mapped as special function registers.
 * Assumes the data RAM answers a read combinationally in the cycle its
 * read strobe is high, and that the core waits for req_ready.
 */
`timescale 1ns/1ps
`default_nettype none
// Notes on behaviour
// - three pointer pairs, each 12 bits wide
// - plain operand reads pointer target, pointer unchanged
// - indirect address ignores bank and access bit
// - post-decrement uses pointer then subtracts one
// - post-increment uses pointer then adds one
// - pre-increment adds one then uses pointer
// - offset operand adds signed working register
// - steps act on whole pair with carry
// - pointer steps never touch status flags
// - pointer at virtual operand: read zero, write ignored
// - own-pair write through operand skips stepping
// - pointer bytes reachable by direct addressing
// - indirect access reaches other special registers
// - extended behaviour only when config bit set
// - extended, access bit 0, low address: pair two offset
// - extended, access bit 0, high address: forced bank
// - access bit 1 uses bank select always
// - extended mode leaves pairs zero, one unchanged
// - access bit chooses bank select or access bank
module data_memory_address_generator (
    input wire logic clk,
    input wire logic srst,
    input wire logic req_valid,
    input wire logic req_write,
    input wire logic access_bit,
    input wire logic [7:0] file_addr,
    input wire logic [7:0] work_reg,
    input wire logic [3:0] bank_select_register,
    input wire logic extended_instruction_config_bit,
    input wire logic [7:0] req_wdata,
    output logic req_ready,
    output logic done,
    output logic [7:0] rd_data,
    output logic [11:0] mem_addr,
    output logic mem_re,
    output logic mem_we,
    output logic [7:0] mem_wdata,
    input wire logic [7:0] mem_rdata
);
    import addr_gen_pkg::*;

    typedef struct packed {
        state_t state;
        logic ready;
        logic done;
        logic mem_re;
        logic mem_we;
        logic [11:0] mem_addr;
        logic [7:0] mem_wdata;
        logic [7:0] rd_data;
        logic rd_from_mem;
    } ctl_t;

    ctl_t st_r;
    ctl_t st_nxt;

    logic [11:0] ptr_q [PAIR_COUNT];
    ptr_op_t ptr_op [PAIR_COUNT];
    logic [11:0] direct_addr;
    logic [11:0] ind_ptr;
    logic [11:0] eff_addr;
    sfr_class_t dir_class;
    sfr_class_t eff_class;
    logic ind_access;
    logic eff_virtual;
    logic req_fire;

    function automatic logic [7:0] ptr_byte(input logic [11:0] p, input logic [2:0] slot);
        return (slot == SLOT_HIGH) ? {HIGH_UNUSED_FILL, p[11:8]} : p[7:0];
    endfunction

    function automatic ptr_op_t byte_write_op(input logic [2:0] slot);
        return (slot == SLOT_HIGH) ? PTR_WR_HI : PTR_WR_LO;
    endfunction

    genvar gi;
    generate
        for (gi = 0; gi < PAIR_COUNT; gi++)
        begin : g_pair
            pointer_pair u_pair (
                .clk(clk),
                .srst(srst),
                .op(ptr_op[gi]),
                .wdata(req_wdata),
                .ptr(ptr_q[gi])
            );
        end
    endgenerate

    operand_address_former u_former (
        .access_bit(access_bit),
        .file_addr(file_addr),
        .bank_select_register(bank_select_register),
        .extended_instruction_config_bit(extended_instruction_config_bit),
        .pair_two_ptr(ptr_q[2]),
        .direct_addr(direct_addr)
    );

    assign req_fire = req_valid && st_r.ready;
    assign dir_class = classify(direct_addr);
    assign ind_access = dir_class.hit && is_virtual(dir_class.slot);
    // indirect target comes from the pointer alone; bank and access bit play no part
    assign ind_ptr = ptr_q[dir_class.pair];
    assign eff_addr = (dir_class.slot == SLOT_PRE_INCREMENT_OPERAND) ? 12'(ind_ptr + PTR_STEP)
                    : (dir_class.slot == SLOT_OFFSET_BY_WORKING_OPERAND) ? 12'(ind_ptr + {{4{work_reg[7]}}, work_reg})
                    : ind_ptr;
    assign eff_class = classify(eff_addr);
    assign eff_virtual = eff_class.hit && is_virtual(eff_class.slot);

    always_comb
    begin
        st_nxt = st_r;
        st_nxt.done = 1'b0;
        st_nxt.mem_re = 1'b0;
        st_nxt.mem_we = 1'b0;
        for (int n = 0; n < PAIR_COUNT; n++)
            ptr_op[n] = PTR_HOLD;
        unique case (st_r.state)
            ST_IDLE:
            begin
                if (req_valid)
                begin
                    st_nxt.state = ST_ACCESS;
                    st_nxt.ready = 1'b0;
                    st_nxt.rd_from_mem = 1'b0;
                    st_nxt.rd_data = RD_NULL;
                    st_nxt.mem_wdata = req_wdata;
                    st_nxt.mem_addr = direct_addr;
                    if (ind_access)
                    begin
                        // steps are applied on the request edge, flags are never driven here
                        if (!eff_virtual && (dir_class.slot == SLOT_POST_INCREMENT_OPERAND || dir_class.slot == SLOT_PRE_INCREMENT_OPERAND))
                            ptr_op[dir_class.pair] = PTR_INC;
                        else if (!eff_virtual && dir_class.slot == SLOT_POST_DECREMENT_OPERAND)
                            ptr_op[dir_class.pair] = PTR_DEC;
                        st_nxt.mem_addr = eff_addr;
                        if (eff_virtual)
                        begin
                            // pointer aimed at a virtual operand: nothing happens
                            st_nxt.rd_data = RD_NULL;
                        end
                        else if (eff_class.hit)
                        begin
                            // byte of a pair reached indirectly; a write replaces the step only when it lands in the stepped pair
                            if (req_write)
                                ptr_op[eff_class.pair] = byte_write_op(eff_class.slot);
                            else
                                st_nxt.rd_data = ptr_byte(ptr_q[eff_class.pair], eff_class.slot);
                        end
                        else
                        begin
                            st_nxt.mem_re = !req_write;
                            st_nxt.mem_we = req_write;
                            st_nxt.rd_from_mem = !req_write;
                        end
                    end
                    else if (dir_class.hit)
                    begin
                        if (req_write)
                            ptr_op[dir_class.pair] = byte_write_op(dir_class.slot);
                        else
                            st_nxt.rd_data = ptr_byte(ptr_q[dir_class.pair], dir_class.slot);
                    end
                    else
                    begin
                        st_nxt.mem_re = !req_write;
                        st_nxt.mem_we = req_write;
                        st_nxt.rd_from_mem = !req_write;
                    end
                end
            end
            ST_ACCESS:
            begin
                st_nxt.state = ST_IDLE;
                st_nxt.ready = 1'b1;
                st_nxt.done = 1'b1;
                if (st_r.rd_from_mem)
                    st_nxt.rd_data = mem_rdata;
            end
            default:
            begin
                st_nxt.state = ST_IDLE;
                st_nxt.ready = 1'b1;
            end
        endcase
    end

    always_ff @(posedge clk)
    begin
        if (srst)
            st_r <= '{state: ST_IDLE, ready: 1'b1, default: '0};
        else
            st_r <= st_nxt;
    end

    assign req_ready = st_r.ready;
    assign done = st_r.done;
    assign rd_data = st_r.rd_data;
    assign mem_addr = st_r.mem_addr;
    assign mem_re = st_r.mem_re;
    assign mem_we = st_r.mem_we;
    assign mem_wdata = st_r.mem_wdata;

    // checks
    default clocking cb @(posedge clk);
    endclocking
    default disable iff (srst);

    logic mem_target;
    assign mem_target = ind_access ? !eff_class.hit : !dir_class.hit;

    AST_DONE_TWO_CYCLES: assert property (
        req_fire |=> !req_ready && !done ##1 req_ready && done)
        else $error("done not two cycles after request");

    AST_BANKED: assert property (
        req_fire && access_bit && !dir_class.hit
        |=> mem_addr == {$past(bank_select_register), $past(file_addr)} && (mem_re || mem_we))
        else $error("banked address wrong");

    AST_FORCED: assert property (
        req_fire && !access_bit && file_addr >= 8'h60 && !dir_class.hit
        |=> mem_addr == {4'hf, $past(file_addr)})
        else $error("forced access address wrong");

    AST_LITERAL_OFFSET: assert property (
        req_fire && extended_instruction_config_bit && !access_bit && file_addr <= 8'h5f && !dir_class.hit
        |=> mem_addr == 12'($past(ptr_q[2]) + {4'h0, $past(file_addr)}))
        else $error("literal offset address wrong");

    AST_ACCESS_BANK_LOW: assert property (
        req_fire && !extended_instruction_config_bit && !access_bit && file_addr < 8'h60
        |=> mem_addr == {4'h0, $past(file_addr)} && (mem_re || mem_we))
        else $error("standard access bank address wrong");

    AST_POST_INCREMENT_OPERAND: assert property (
        req_fire && ind_access && dir_class.pair == 2'h0 && dir_class.slot == SLOT_POST_INCREMENT_OPERAND && !eff_class.hit
        |=> mem_addr == $past(ptr_q[0]) && ptr_q[0] == 12'($past(ptr_q[0]) + 12'h001))
        else $error("post-increment wrong");

    AST_POST_DECREMENT_OPERAND: assert property (
        req_fire && ind_access && dir_class.pair == 2'h1 && dir_class.slot == SLOT_POST_DECREMENT_OPERAND && !eff_class.hit
        |=> mem_addr == $past(ptr_q[1]) && ptr_q[1] == 12'($past(ptr_q[1]) - 12'h001))
        else $error("post-decrement wrong");

    AST_PRE_INCREMENT_OPERAND: assert property (
        req_fire && ind_access && dir_class.pair == 2'h2 && dir_class.slot == SLOT_PRE_INCREMENT_OPERAND && !eff_class.hit
        |=> mem_addr == 12'($past(ptr_q[2]) + 12'h001) && ptr_q[2] == mem_addr)
        else $error("pre-increment wrong");

    AST_PLAIN_KEEPS: assert property (
        req_fire && ind_access && dir_class.slot == SLOT_PLAIN && !eff_class.hit && dir_class.pair == 2'h0
        |=> mem_addr == $past(ptr_q[0]) && $stable(ptr_q[0]))
        else $error("plain operand moved pointer");

    AST_OFFSET_BY_WORKING_OPERAND: assert property (
        req_fire && ind_access && dir_class.slot == SLOT_OFFSET_BY_WORKING_OPERAND && !eff_class.hit && dir_class.pair == 2'h1
        |=> mem_addr == 12'($past(ptr_q[1]) + {{4{$past(work_reg[7])}}, $past(work_reg)}) && $stable(ptr_q[1]))
        else $error("offset operand wrong");

    AST_VIRTUAL_NULL: assert property (
        req_fire && ind_access && eff_virtual
        |=> !mem_re && !mem_we ##1 done && rd_data == 8'h00)
        else $error("virtual target not null");

    AST_OWN_WRITE: assert property (
        req_fire && req_write && ind_access && eff_class.hit && eff_class.pair == dir_class.pair
        && eff_class.slot == SLOT_LOW && dir_class.pair == 2'h2
        |=> ptr_q[2] == {$past(ptr_q[2][11:8]), $past(req_wdata)} && !mem_we)
        else $error("own pair write stepped");

    AST_DIRECT_LOW_READ: assert property (
        req_fire && !req_write && !ind_access && dir_class.hit && dir_class.slot == SLOT_LOW
        |=> ##1 done && rd_data == $past(ptr_q[dir_class.pair][7:0], 2))
        else $error("direct pointer read wrong");

    AST_MEM_STROBE: assert property (
        req_fire
        |=> (mem_re || mem_we) == $past(mem_target))
        else $error("strobe on wrong target");

    AST_PTRS_QUIET: assert property (
        !req_fire
        |=> $stable(ptr_q[0]) && $stable(ptr_q[1])
        && $stable(ptr_q[2]))
        else $error("pointer moved while idle");

    AST_HIGH_READ: assert property (
        req_fire && !req_write && !ind_access
        && dir_class.hit && dir_class.slot == SLOT_HIGH
        |=> ##1 rd_data
        == {4'h0, $past(ptr_q[dir_class.pair][11:8], 2)})
        else $error("high byte read wrong");

    AST_VIRTUAL_HOLD: assert property (
        req_fire && ind_access && eff_virtual
        |=> ptr_q[$past(dir_class.pair)]
        == $past(ptr_q[dir_class.pair]))
        else $error("virtual target stepped");

    AST_HIGH_WRITE: assert property (
        req_fire && req_write && !ind_access
        && dir_class.hit && dir_class.slot == SLOT_HIGH
        |=> ptr_q[$past(dir_class.pair)]
        == {$past(req_wdata[3:0]), $past(ptr_q[dir_class.pair][7:0])})
        else $error("high byte write wrong");

    AST_EXT_PAIRS: assert property (
        req_fire && extended_instruction_config_bit && ind_access
        && dir_class.pair != 2'h2
        && dir_class.slot == SLOT_PLAIN && !eff_class.hit
        |=> mem_addr == $past(ptr_q[dir_class.pair]))
        else $error("extended mode moved pair");

    AST_WRITE_DATA: assert property (
        req_fire && req_write
        |=> mem_wdata == $past(req_wdata))
        else $error("write data not copied");

    AST_BANK_IGNORED: assert property (
        req_fire && ind_access && access_bit
        && dir_class.slot == SLOT_PLAIN && !eff_class.hit
        |=> mem_addr == $past(ptr_q[dir_class.pair]))
        else $error("bank used indirectly");

    CVR_POST_INCREMENT_OPERAND_WALK: cover property (
        req_fire && ind_access && dir_class.slot == SLOT_POST_INCREMENT_OPERAND ##2 req_fire && ind_access);
    CVR_LITERAL_OFFSET: cover property (
        req_fire && extended_instruction_config_bit && !access_bit && file_addr <= 8'h5f);
    CVR_VIRTUAL_NULL: cover property (req_fire && ind_access && eff_virtual);
    CVR_OWN_WRITE: cover property (req_fire && req_write && ind_access && eff_class.hit);

endmodule
`default_nettype wire

/* File: verification/data_ram_model.sv */
/*
 * Data RAM and SFR space behind the address generator: 4096 bytes.
 * Assumes the generator holds address and strobes for the strobe cycle;
 * reads answer combinationally, writes land on the clock edge.
 */
`timescale 1ns/1ps
`default_nettype none
module data_ram_model (
    input wire logic clk,
    input wire logic [11:0] mem_addr,
    input wire logic mem_re,
    input wire logic mem_we,
    input wire logic [7:0] mem_wdata,
    output logic [7:0] mem_rdata
);
    logic [7:0] cells [4096];
    logic [7:0] idle_r;

    initial
    begin
        idle_r = 8'h5a;
        for (int i = 0; i < 4096; i++)
            cells[i] = 8'(i) ^ {4'(i >> 8), 4'h9};
    end

    // outside a read strobe the data lines show a pattern that changes every cycle
    always @(posedge clk)
    begin
        idle_r <= ~idle_r + 8'h01;
        if (mem_we === 1'b1)
            cells[mem_addr] <= mem_wdata;
    end

    assign mem_rdata = (mem_re === 1'b1) ? cells[mem_addr] : idle_r;
endmodule
`default_nettype wire

/* File: verification/data_memory_address_generator_tb.sv */
/*
 * Self-checking bench for the operand address generator: a reference
 * model predicts every access into a queue, a watcher compares outputs.
 * Assumes the data RAM model answers reads within the strobe cycle.
 */
`timescale 1ns/1ps
`default_nettype none
module data_memory_address_generator_tb;
    typedef struct {
        logic mem;
        logic we;
        logic [11:0] addr;
        logic [7:0] wd;
        logic [7:0] rd;
    } exp_t;
    logic clk, srst, req_valid, req_write, access_bit, extended_instruction_config_bit;
    logic [7:0] file_addr, work_reg, req_wdata, rd_data, mem_wdata, mem_rdata;
    logic [3:0] bank_select_register;
    logic [11:0] mem_addr;
    logic req_ready, done, mem_re, mem_we, junk, seen;
    logic [11:0] ptr [3];
    logic [7:0] shadow [4096];
    logic [31:0] r, r2;
    // {access bit, extended, bank, file address}
    logic [13:0] forms [6] = '{14'h0510, 14'h1510, 14'h105f, 14'h1060, 14'h3310, 14'h2f5f};
    exp_t q [$];
    exp_t hd;
    int bad_count, num_checks;
    integer seed;

    data_memory_address_generator dut_u (.clk(clk), .srst(srst), .req_valid(req_valid),
        .req_write(req_write), .access_bit(access_bit), .file_addr(file_addr), .work_reg(work_reg),
        .bank_select_register(bank_select_register),
        .extended_instruction_config_bit(extended_instruction_config_bit), .req_wdata(req_wdata),
        .req_ready(req_ready), .done(done), .rd_data(rd_data), .mem_addr(mem_addr), .mem_re(mem_re),
        .mem_we(mem_we), .mem_wdata(mem_wdata), .mem_rdata(mem_rdata));
    data_ram_model ram_u (.clk(clk), .mem_addr(mem_addr), .mem_re(mem_re), .mem_we(mem_we),
        .mem_wdata(mem_wdata), .mem_rdata(mem_rdata));

    initial
    begin
        clk = 1'b0;
        forever #5 clk = ~clk;
    end

    task automatic check(input logic [11:0] got, input logic [11:0] want, input string what);
        num_checks++;
        if (got !== want)
        begin
            bad_count++;
            $display("[FAIL] %0t %s: got %h want %h", $time, what, got, want);
        end
    endtask

    task automatic wrap_up();
        $display("checks %0d mismatches %0d", num_checks, bad_count);
        if (bad_count == 0 && num_checks > 0)
            $display("TB: PASS");
        else
            $display("TB: FAIL");
        $finish;
    endtask

    // index 8*pair+slot of a pointer register address, -1 elsewhere
    function automatic int loc(input logic [11:0] ad);
        logic [11:0] d;
        for (int n = 0; n < 3; n++)
        begin
            d = 12'hfef - 12'(8 * n) - ad;
            if (d <= 12'h006)
                return 8 * n + int'(d);
        end
        return -1;
    endfunction

    task automatic issue(input logic wr, input logic a, input logic [7:0] f, input logic [7:0] w,
                         input logic [3:0] b, input logic x, input logic [7:0] wd);
        exp_t e;
        logic [11:0] ad;
        logic [11:0] pv [3];
        int c;
        int s;
        logic virt;
        e = '{1'b0, wr, 12'h000, wd, 8'h00};
        pv = ptr;
        virt = 1'b0;
        ad = a ? {b, f} : (x && f <= 8'h5f) ? ptr[2] + {4'h0, f} : (f >= 8'h60) ? {4'hf, f} : {4'h0, f};
        c = loc(ad);
        if (c >= 0 && c % 8 <= 4)
        begin
            s = c % 8;
            ad = ptr[c / 8] + (s == 3 ? 12'h001 : s == 4 ? {{4{w[7]}}, w} : 12'h000);
            virt = loc(ad) >= 0 && loc(ad) % 8 <= 4;
            if (!virt)
                ptr[c / 8] = ptr[c / 8] + (s == 1 || s == 3 ? 12'h001 : s == 2 ? 12'hfff : 12'h000);
            c = loc(ad);
        end
        if (!virt && c >= 0)
        begin
            e.rd = c % 8 == 5 ? {4'h0, pv[c / 8][11:8]} : pv[c / 8][7:0];
            if (wr)
                ptr[c / 8] = c % 8 == 5 ? {wd[3:0], pv[c / 8][7:0]} : {pv[c / 8][11:8], wd};
        end
        else if (!virt)
        begin
            e.mem = 1'b1;
            e.addr = ad;
            e.rd = shadow[ad];
            if (wr)
                shadow[ad] = wd;
        end
        @(posedge clk);
        req_valid <= 1'b1;
        req_write <= wr;
        access_bit <= a;
        file_addr <= f;
        work_reg <= w;
        bank_select_register <= b;
        extended_instruction_config_bit <= x;
        req_wdata <= wd;
        q.push_back(e);
        @(posedge clk);
        // a junk request while busy must be ignored
        req_valid <= junk;
        file_addr <= ~f;
        req_write <= 1'b1;
        if (junk)
        begin
            @(posedge clk);
            req_valid <= 1'b0;
        end
    endtask

    task automatic op(input int n, input int s, input logic wr, input logic [7:0] wd, input logic [7:0] w);
        issue(wr, 1'b0, 8'(8'hef - 8 * n - s), w, 4'h0, 1'b0, wd);
    endtask

    task automatic setp(input int n, input logic [11:0] v);
        op(n, 5, 1'b1, {4'ha, v[11:8]}, 8'h00);
        op(n, 6, 1'b1, v[7:0], 8'h00);
    endtask

    always @(posedge clk)
    begin
        if (srst === 1'b0)
        begin
            if (mem_re === 1'b1 || mem_we === 1'b1)
            begin
                seen = 1'b1;
                if (q.size() == 0)
                    check(12'h001, 12'h000, "unexpected strobe");
                else
                begin
                    check(mem_we, q[0].we, "write strobe");
                    check(mem_addr, q[0].addr, "address");
                    if (q[0].we)
                        check(mem_wdata, q[0].wd, "write data");
                end
            end
            if (done === 1'b1)
            begin
                if (q.size() == 0)
                    check(12'h001, 12'h000, "extra done");
                else
                begin
                    hd = q.pop_front();
                    check(seen, hd.mem, "memory strobe");
                    if (!hd.we)
                        check(rd_data, hd.rd, "read data");
                end
                seen = 1'b0;
            end
        end
    end

    initial
    begin
        srst = 1'b1;
        req_valid = 1'b0;
        req_write = 1'b0;
        access_bit = 1'b0;
        file_addr = 8'h00;
        work_reg = 8'h00;
        bank_select_register = 4'h0;
        extended_instruction_config_bit = 1'b0;
        req_wdata = 8'h00;
        seed = 32'h7797;
        junk = 1'b0;
        seen = 1'b0;
        bad_count = 0;
        num_checks = 0;
        ptr = '{default: 12'h000};
        for (int i = 0; i < 4096; i++)
            shadow[i] = 8'(i) ^ {4'(i >> 8), 4'h9};
        repeat (4) @(posedge clk);
        srst <= 1'b0;
        #1;
        check(req_ready, 12'h001, "ready after reset");
        check(done, 12'h000, "done after reset");
        for (int n = 0; n < 3; n++)
        begin
            op(n, 5, 1'b0, 8'h00, 8'h00);
            op(n, 6, 1'b0, 8'h00, 8'h00);
        end
        setp(0, 12'h1ff);
        op(0, 5, 1'b0, 8'h00, 8'h00);
        op(0, 1, 1'b1, 8'h3c, 8'h00);
        op(0, 2, 1'b0, 8'h00, 8'h00);
        op(0, 0, 1'b0, 8'h00, 8'h00);
        op(0, 3, 1'b0, 8'h00, 8'h00);
        foreach (forms[i])
            op(0, 4, 1'b0, 8'h00, forms[i][7:0] ^ 8'hdf);
        setp(1, 12'hfff);
        op(1, 1, 1'b1, 8'h11, 8'h00);
        op(1, 2, 1'b0, 8'h00, 8'h00);
        op(1, 0, 1'b0, 8'h00, 8'h00);
        setp(0, 12'hfe7);
        op(0, 0, 1'b0, 8'h00, 8'h00);
        op(0, 1, 1'b0, 8'h00, 8'h00);
        junk = 1'b1;
        op(0, 0, 1'b1, 8'h99, 8'h00);
        junk = 1'b0;
        op(1, 6, 1'b0, 8'h00, 8'h00);
        setp(2, 12'hfd9);
        op(2, 2, 1'b1, 8'h34, 8'h00);
        op(2, 6, 1'b0, 8'h00, 8'h00);
        op(2, 5, 1'b0, 8'h00, 8'h00);
        setp(0, 12'hf80);
        op(0, 0, 1'b1, 8'h77, 8'h00);
        issue(1'b0, 1'b0, 8'hef, 8'h00, 4'h0, 1'b1, 8'h00);
        issue(1'b0, 1'b1, 8'he7, 8'h00, 4'hf, 1'b0, 8'h00);
        for (int k = 0; k < 2; k++)
        begin
            setp(2, k == 0 ? 12'hf34 : 12'hff0);
            foreach (forms[i])
                issue(1'b0, forms[i][13], forms[i][7:0], 8'h00, forms[i][11:8], forms[i][12], 8'h00);
        end
        for (int n = 0; n < 3; n++)
        begin
            r = $random(seed);
            setp(n, r[11:0] & 12'h7ff);
        end
        repeat (150)
        begin
            r = $random(seed);
            r2 = $random(seed);
            // keep pointers out of the special register block
            if (r[0] && loc({r[1] ? r[27:24] : 4'hf, r[15:8]}) % 8 == 5)
                r2[3] = 1'b0;
            issue(r[0], r[1], r[15:8], r[23:16], r[27:24], r[2], r2[7:0]);
        end
        repeat (4) @(posedge clk);
        check(12'(q.size()), 12'h000, "requests left without done");
        wrap_up();
    end

    initial
    begin
        repeat (5000) @(posedge clk);
        bad_count++;
        wrap_up();
    end
endmodule
`default_nettype wire
